//--- shared/gpirq_pkg.sv
package gpirq_pkg;

   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } gpirq_bus_t;

   localparam int NUM_GROUPS = 10;
   localparam int NUM_TMODS  = 8;

   localparam logic [7:0] OFF_CORE    = 8'h00;
   localparam logic [7:0] OFF_GFLAG_L = 8'h01;
   localparam logic [7:0] OFF_GFLAG_H = 8'h02;
   localparam logic [7:0] OFF_GEN_L   = 8'h03;
   localparam logic [7:0] OFF_GEN_H   = 8'h04;
   localparam logic [7:0] OFF_SRC0    = 8'h10;
   localparam logic [7:0] OFF_PSC0    = 8'h20;
   localparam logic [7:0] OFF_PSC1    = 8'h21;
   localparam logic [7:0] OFF_PTB0    = 8'h22;
   localparam logic [7:0] OFF_PTB1    = 8'h23;

   localparam int CORE_GLOB_BIT = 0;
   localparam int CORE_CEN_BIT  = 1;
   localparam int CORE_CFL_BIT  = 2;
   localparam int SRC_EXF_BIT   = 6;
   localparam int SRC_AF_BIT    = 5;
   localparam int SRC_PF_BIT    = 4;
   localparam int SRC_EXE_BIT   = 2;
   localparam int SRC_AE_BIT    = 1;
   localparam int SRC_PE_BIT    = 0;
   localparam int PTB_ON_BIT    = 7;

   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [9:0] RST_GRP   = 10'h000;
   localparam logic [7:0] EX_MASK   = 8'hF0;
   localparam logic [1:0] SEL_SYS   = 2'h0;
   localparam logic [1:0] SEL_DIV4  = 2'h1;
   localparam logic [1:0] DIV4_LAST = 2'h3;
   localparam logic [3:0] VEC_CONV  = 4'h0;
   localparam logic [3:0] VEC_GRP0  = 4'h1;

endpackage

//--- core/gpirq_tbase.sv
`timescale 1ns/1ns
module gpirq_tbase
   import gpirq_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic [1:0] src_sel,
   input  wire logic       tb_on,
   input  wire logic [2:0] period_sel,
   input  wire logic       sub_rise,
   output logic            ovf_q
);

   logic [1:0]  div_q;
   logic [14:0] cnt_q;
   logic        tick;
   logic [14:0] mask;

   function automatic logic [14:0] period_mask(input logic [2:0] p);
      logic [15:0] m;
      m = (16'h0100 << p) - 16'h0001;
      return m[14:0];
   endfunction

   // Prescaler clock source: system clock, system clock over four, or sub clock edges.
   always_comb
   begin
      unique case (src_sel)
         SEL_SYS:  tick = 1'b1;
         SEL_DIV4: tick = (div_q == DIV4_LAST);
         default:  tick = sub_rise;
      endcase
      mask = period_mask(period_sel);
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         div_q <= 2'h0;
      else
         div_q <= div_q + 2'h1;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         cnt_q <= 15'h0000;
      else if (!tb_on)
         cnt_q <= 15'h0000;
      else if (tick)
         cnt_q <= ((cnt_q & mask) == mask) ? 15'h0000 : cnt_q + 15'h0001;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         ovf_q <= 1'b0;
      else
         ovf_q <= tb_on && tick && ((cnt_q & mask) == mask);
   end

endmodule

//--- core/gpirq_core.sv
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
module gpirq_core
   import gpirq_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire gpirq_bus_t bus,
   output logic [7:0]      rdata_q,
   input  wire logic       conv_done,
   input  wire logic [7:0] tm_match_a,
   input  wire logic [7:0] tm_match_p,
   input  wire logic [1:0] cmp_out,
   input  wire logic [1:0] other_req,
   input  wire logic       sub_clock,
   input  wire logic       stack_full,
   input  wire logic       irq_ack,
   output logic            irq_req_q,
   output logic [3:0]      irq_vector_q,
   output logic            wake_q
);

   logic       glob_q, conv_en_q, conv_flag_q;
   logic [9:0] gflag_q, gen_q;
   logic [7:0] a_flag_q, p_flag_q, ex_flag_q;
   logic [7:0] a_en_q, p_en_q, ex_en_q;
   logic [1:0] psc0_q, psc1_q;
   logic [7:0] ptb0_q, ptb1_q;
   logic [2:0] syn1_q, syn2_q, syn3_q, st_q;
   logic [23:0] act_q;

   logic       glob_d, conv_flag_d;
   logic [9:0] gflag_d;
   logic [7:0] a_flag_d, p_flag_d, ex_flag_d;
   logic [2:0] st_d;
   logic [1:0] cmp_chg, ovf;
   logic       sub_rise, svc, req_d;
   logic [3:0] vec_d;
   logic [23:0] act_now;
   logic [9:0] gset, grp_ok;

   function automatic logic wr_at(input gpirq_bus_t b, input logic [7:0] a);
      return b.wr && (b.addr == a);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers for the sub clock and the comparator outputs.

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         syn1_q <= 3'h0;
         syn2_q <= 3'h0;
         syn3_q <= 3'h0;
         st_q   <= 3'h0;
      end
      else
      begin
         syn1_q <= {sub_clock, cmp_out};
         syn2_q <= syn1_q;
         syn3_q <= syn2_q;
         st_q   <= st_d;
      end
   end

   // A level counts only once the second and third stages agree.
   always_comb
   begin
      st_d     = (syn2_q & syn3_q) | (st_q & (syn2_q | syn3_q));
      cmp_chg  = st_d[1:0] ^ st_q[1:0];
      sub_rise = st_d[2] & ~st_q[2];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Time bases.

   gpirq_tbase u_tb0
   (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .src_sel    (psc0_q),
      .tb_on      (ptb0_q[PTB_ON_BIT]),
      .period_sel (ptb0_q[2:0]),
      .sub_rise   (sub_rise),
      .ovf_q      (ovf[0])
   );

   gpirq_tbase u_tb1
   (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .src_sel    (psc1_q),
      .tb_on      (ptb1_q[PTB_ON_BIT]),
      .period_sel (ptb1_q[2:0]),
      .sub_rise   (sub_rise),
      .ovf_q      (ovf[1])
   );

   ////////////////////////////////////////////////////////////////////////////
   // Request flags. A hardware set always wins over a clear in the same cycle.

   assign svc = irq_req_q && irq_ack;

   always_comb
   begin
      conv_flag_d = wr_at(bus, OFF_CORE) ? bus.wdata[CORE_CFL_BIT] : conv_flag_q;
      if (svc && (irq_vector_q == VEC_CONV))
         conv_flag_d = 1'b0;
      conv_flag_d = conv_flag_d | conv_done;
      glob_d = glob_q;
      if (svc)
         glob_d = 1'b0;
      if (wr_at(bus, OFF_CORE))
         glob_d = bus.wdata[CORE_GLOB_BIT];
      a_flag_d  = a_flag_q;
      p_flag_d  = p_flag_q;
      ex_flag_d = ex_flag_q;
      for (int i = 0; i < NUM_TMODS; i++)
      begin
         if (wr_at(bus, OFF_SRC0 + 8'(i)))
         begin
            a_flag_d[i]  = bus.wdata[SRC_AF_BIT];
            p_flag_d[i]  = bus.wdata[SRC_PF_BIT];
            ex_flag_d[i] = bus.wdata[SRC_EXF_BIT];
         end
      end
      a_flag_d  = a_flag_d | tm_match_a;
      p_flag_d  = p_flag_d | tm_match_p;
      ex_flag_d = (ex_flag_d | {ovf, cmp_chg, 4'h0}) & EX_MASK;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         conv_flag_q <= 1'b0;
         glob_q      <= 1'b0;
         a_flag_q    <= RST_BYTE;
         p_flag_q    <= RST_BYTE;
         ex_flag_q   <= RST_BYTE;
      end
      else
      begin
         conv_flag_q <= conv_flag_d;
         glob_q      <= glob_d;
         a_flag_q    <= a_flag_d;
         p_flag_q    <= p_flag_d;
         ex_flag_q   <= ex_flag_d;
      end
   end

   // Group flags 0 to 7 take a member only while its own enable is set; groups 8 and 9 take other_req directly.
   always_comb
   begin
      for (int i = 0; i < NUM_TMODS; i++)
         act_now[3*i +: 3] = {ex_flag_q[i] & ex_en_q[i], a_flag_q[i] & a_en_q[i], p_flag_q[i] & p_en_q[i]};
      for (int i = 0; i < NUM_TMODS; i++)
         gset[i] = |(act_now[3*i +: 3] & ~act_q[3*i +: 3]);
      gset[9:8] = other_req;
      gflag_d = gflag_q;
      if (wr_at(bus, OFF_GFLAG_L))
         gflag_d[7:0] = bus.wdata;
      if (wr_at(bus, OFF_GFLAG_H))
         gflag_d[9:8] = bus.wdata[1:0];
      if (svc && (irq_vector_q != VEC_CONV))
         gflag_d[irq_vector_q - VEC_GRP0] = 1'b0;
      gflag_d = gflag_d | gset;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         act_q   <= 24'h000000;
         gflag_q <= RST_GRP;
      end
      else
      begin
         act_q   <= act_now;
         gflag_q <= gflag_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enables and time-base control.

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         conv_en_q <= 1'b0;
         gen_q     <= RST_GRP;
         a_en_q    <= RST_BYTE;
         p_en_q    <= RST_BYTE;
         ex_en_q   <= RST_BYTE;
         psc0_q    <= 2'h0;
         psc1_q    <= 2'h0;
         ptb0_q    <= RST_BYTE;
         ptb1_q    <= RST_BYTE;
      end
      else
      begin
         if (wr_at(bus, OFF_CORE))
            conv_en_q <= bus.wdata[CORE_CEN_BIT];
         if (wr_at(bus, OFF_GEN_L))
            gen_q[7:0] <= bus.wdata;
         if (wr_at(bus, OFF_GEN_H))
            gen_q[9:8] <= bus.wdata[1:0];
         for (int i = 0; i < NUM_TMODS; i++)
         begin
            if (wr_at(bus, OFF_SRC0 + 8'(i)))
            begin
               a_en_q[i]  <= bus.wdata[SRC_AE_BIT];
               p_en_q[i]  <= bus.wdata[SRC_PE_BIT];
               ex_en_q[i] <= bus.wdata[SRC_EXE_BIT] & EX_MASK[i];
            end
         end
         if (wr_at(bus, OFF_PSC0))
            psc0_q <= bus.wdata[1:0];
         if (wr_at(bus, OFF_PSC1))
            psc1_q <= bus.wdata[1:0];
         if (wr_at(bus, OFF_PTB0))
            ptb0_q <= bus.wdata & 8'h87;
         if (wr_at(bus, OFF_PTB1))
            ptb1_q <= bus.wdata & 8'h87;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Dispatch: conversion first, then groups from 0 upward.

   always_comb
   begin
      grp_ok = gflag_q & gen_q;
      vec_d  = VEC_CONV;
      for (int i = NUM_GROUPS - 1; i >= 0; i--)
         if (grp_ok[i])
            vec_d = VEC_GRP0 + 4'(i);
      if (conv_flag_q && conv_en_q)
         vec_d = VEC_CONV;
      req_d = glob_q && !stack_full && ((conv_flag_q && conv_en_q) || (|grp_ok)) && !svc;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irq_req_q    <= 1'b0;
         irq_vector_q <= VEC_CONV;
      end
      else
      begin
         irq_req_q <= req_d;
         if (req_d)
            irq_vector_q <= vec_d;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         wake_q <= 1'b0;
      else
         wake_q <= |({conv_flag_d, gflag_d, a_flag_d, p_flag_d, ex_flag_d}
                     & ~{conv_flag_q, gflag_q, a_flag_q, p_flag_q, ex_flag_q});
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read port.

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         rdata_q <= RST_BYTE;
      else if (!bus.rd)
         rdata_q <= RST_BYTE;
      else if ((bus.addr & 8'hF8) == OFF_SRC0)
         rdata_q <= {1'b0, ex_flag_q[bus.addr[2:0]], a_flag_q[bus.addr[2:0]], p_flag_q[bus.addr[2:0]],
                     1'b0, ex_en_q[bus.addr[2:0]], a_en_q[bus.addr[2:0]], p_en_q[bus.addr[2:0]]};
      else
      begin
         unique case (bus.addr)
            OFF_CORE:    rdata_q <= {5'h00, conv_flag_q, conv_en_q, glob_q};
            OFF_GFLAG_L: rdata_q <= gflag_q[7:0];
            OFF_GFLAG_H: rdata_q <= {6'h00, gflag_q[9:8]};
            OFF_GEN_L:   rdata_q <= gen_q[7:0];
            OFF_GEN_H:   rdata_q <= {6'h00, gen_q[9:8]};
            OFF_PSC0:    rdata_q <= {6'h00, psc0_q};
            OFF_PSC1:    rdata_q <= {6'h00, psc1_q};
            OFF_PTB0:    rdata_q <= ptb0_q;
            OFF_PTB1:    rdata_q <= ptb1_q;
            default:     rdata_q <= RST_BYTE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   conv_set_a: assert property (@(posedge ref_clk) disable iff (!nrst) conv_done |=> conv_flag_q)
      else $error("conversion finish did not set its flag");
   conv_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(irq_req_q) && irq_vector_q == VEC_CONV |-> $past(glob_q && conv_en_q && conv_flag_q))
      else $error("conversion vector taken without its enables");
   stack_wait_a: assert property (@(posedge ref_clk) disable iff (!nrst) stack_full |=> !irq_req_q)
      else $error("request raised while stack full");
   conv_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      svc && irq_vector_q == VEC_CONV && !conv_done && !bus.wr |=> !conv_flag_q)
      else $error("conversion flag kept after service");
   glob_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      svc && !wr_at(bus, OFF_CORE) |=> !glob_q ##1 !irq_req_q)
      else $error("global enable kept after service");
   src_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      svc && irq_vector_q != VEC_CONV && !bus.wr |=> a_flag_q == ($past(a_flag_q) | $past(tm_match_a)))
      else $error("group service changed a member flag");
   cmp_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst) cmp_chg[0] |=> ex_flag_q[4])
      else $error("comparator change did not set its flag");
   tb_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst) ovf[1] |=> ex_flag_q[7])
      else $error("time-base overflow did not set its flag");
   wake_rise_a: assert property (@(posedge ref_clk) disable iff (!nrst) $rose(conv_flag_q) |-> wake_q)
      else $error("flag rise gave no wake");
   one_vector_a: assert property (@(posedge ref_clk) disable iff (!nrst) svc |=> !irq_req_q)
      else $error("second vector without new service entry");

endmodule

//--- verif/gpirq_cpu_model.sv
`timescale 1ns/1ns
module gpirq_cpu_model
   import gpirq_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic slow,
   input  wire logic irq_req_q,
   output logic      irq_ack
);
   logic [1:0] wait_q;

   ////////////////////////////////////////////////////////////////////////////////
   // A standing request is taken with a one-cycle pulse, after three more cycles when slow.
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irq_ack <= 1'b0;
         wait_q  <= 2'h0;
      end
      else if (irq_ack || !irq_req_q)
      begin
         irq_ack <= 1'b0;
         wait_q  <= 2'h0;
      end
      else if (!slow || wait_q == 2'h3)
         irq_ack <= 1'b1;
      else
         wait_q <= wait_q + 2'h1;
   end
endmodule

//--- verif/tb.sv
`timescale 1ns/1ns
module tb;
   import gpirq_pkg::*;
   typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rback;} gpirq_row_t;
   typedef struct packed {logic u; logic [1:0] sel; logic [2:0] per; logic [15:0] lo; logic [15:0] hi;} gpirq_tbrow_t;

   logic         ref_clk;
   logic         nrst;
   gpirq_bus_t   bus;
   logic [7:0]   rdata_q;
   logic [18:0]  ev;
   logic         conv_done;
   logic [7:0]   tm_match_a;
   logic [7:0]   tm_match_p;
   logic [1:0]   cmp_out;
   logic [1:0]   other_req;
   logic         sub_clock;
   logic         stack_full;
   logic         irq_ack;
   logic         irq_req_q;
   logic [3:0]   irq_vector_q;
   logic         wake_q;
   logic         slow;
   logic [7:0]   d;
   logic         seen;
   int           err_count;
   int           n_compared;
   int           cyc;
   int           k;
   int           cnt;
   gpirq_row_t   rows [8] = '{'{OFF_PSC0, 8'hFF, 8'h03}, '{OFF_PSC1, 8'hFF, 8'h03}, '{OFF_PTB0, 8'hFF, 8'h87},
                              '{OFF_PTB1, 8'hFF, 8'h87}, '{OFF_SRC0, 8'h70, 8'h30}, '{8'h14, 8'h70, 8'h70},
                              '{OFF_GEN_H, 8'hFF, 8'h03}, '{8'h30, 8'hFF, 8'h00}};
   gpirq_tbrow_t tbs [5] = '{'{1'b0, 2'h0, 3'h0, 16'd250, 16'd280}, '{1'b1, 2'h1, 3'h0, 16'd1010, 16'd1060},
                              '{1'b0, 2'h0, 3'h1, 16'd500, 16'd540}, '{1'b1, 2'h2, 3'h0, 16'd2020, 16'd2110},
                              '{1'b0, 2'h3, 3'h0, 16'd2020, 16'd2110}};

   assign {other_req, tm_match_p, tm_match_a, conv_done} = ev;

   gpirq_core dut (.ref_clk(ref_clk), .nrst(nrst), .bus(bus), .rdata_q(rdata_q), .conv_done(conv_done),
                   .tm_match_a(tm_match_a), .tm_match_p(tm_match_p), .cmp_out(cmp_out), .other_req(other_req),
                   .sub_clock(sub_clock), .stack_full(stack_full), .irq_ack(irq_ack), .irq_req_q(irq_req_q),
                   .irq_vector_q(irq_vector_q), .wake_q(wake_q));
   gpirq_cpu_model core (.ref_clk(ref_clk), .nrst(nrst), .slow(slow), .irq_req_q(irq_req_q), .irq_ack(irq_ack));

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // The sub clock free-runs at one eighth of the system rate, out of phase with it.
   initial
   begin
      sub_clock = 1'b0;
      #3;
      forever #40 sub_clock = ~sub_clock;
   end

   always @(posedge ref_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         err_count = err_count + 1;
         results();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task results();
      if (err_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
         err_count = err_count + 1;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task chk1(input string name, input logic exp, input logic got);
      chk8(name, {7'h00, exp}, {7'h00, got});
   endtask

   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus.wr <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      @(negedge ref_clk);
      v = rdata_q;
   endtask

   task rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk8("register", exp, v);
   endtask

   task hit(input logic [18:0] v);
      @(posedge ref_clk);
      ev <= v;
      @(posedge ref_clk);
      ev <= '0;
   endtask

   task take(input logic [3:0] v);
      logic f;
      f = 1'b0;
      for (int i = 0; i < 60 && !f; i++)
      begin
         @(negedge ref_clk);
         f = (irq_req_q === 1'b1 && irq_ack === 1'b1);
      end
      if (f)
         chk8("irq_vector_q", {4'h0, v}, {4'h0, irq_vector_q});
      else
         chk1("irq_req_q", 1'b1, 1'b0);
   endtask

   task quiet(input int n);
      logic s;
      s = 1'b0;
      repeat (n) @(negedge ref_clk) if (irq_req_q !== 1'b0) s = 1'b1;
      chk1("irq_req_q", 1'b0, s);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      bus = '0; ev = '0; cmp_out = 2'h0; stack_full = 1'b0; slow = 1'b0; nrst = 1'b0;
      err_count = 0; n_compared = 0; cyc = 0;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      foreach (rows[r])
      begin
         rdchk(rows[r].addr, 8'h00);
         wr(rows[r].addr, rows[r].wdata);
         rdchk(rows[r].addr, rows[r].rback);
         wr(rows[r].addr, 8'h00);
      end
      // Conversion request held back by the global enable, then by a full stack.
      wr(OFF_CORE, 8'h02);
      hit(19'h1);
      seen = 1'b0;
      repeat (4) @(negedge ref_clk) if (wake_q === 1'b1) seen = 1'b1;
      chk1("wake_q", 1'b1, seen);
      quiet(10);
      rdchk(OFF_CORE, 8'h06);
      @(posedge ref_clk) stack_full <= 1'b1;
      wr(OFF_CORE, 8'h07);
      quiet(10);
      @(posedge ref_clk) stack_full <= 1'b0;
      take(VEC_CONV);
      rdchk(OFF_CORE, 8'h02);
      // Every timer match source and both other sources, one group at a time.
      wr(OFF_GEN_L, 8'hFF);
      wr(OFF_GEN_H, 8'h03);
      for (int n = 0; n < 18; n++)
      begin
         k = (n < 16) ? n / 2 : n - 8;
         if (k < 8)
            wr(OFF_SRC0 + 8'(k), (n % 2) ? 8'h01 : 8'h02);
         wr(OFF_CORE, 8'h01);
         hit(19'h1 << ((n >= 16) ? n + 1 : ((n % 2) ? 9 + k : 1 + k)));
         take(VEC_GRP0 + 4'(k));
         rdchk((k < 8) ? OFF_GFLAG_L : OFF_GFLAG_H, 8'h00);
         if (k < 8)
         begin
            rdchk(OFF_SRC0 + 8'(k), (n % 2) ? 8'h11 : 8'h22);
            wr(OFF_SRC0 + 8'(k), 8'h00);
         end
      end
      // A match whose own enable is off raises no request, even with the global enable set.
      wr(OFF_SRC0, 8'h01);
      wr(OFF_CORE, 8'h01);
      hit(19'h2);
      quiet(10);
      rdchk(OFF_SRC0, 8'h21);
      wr(OFF_SRC0, 8'h00);
      // Comparator change with its group disabled, then enabled.
      wr(OFF_GEN_L, 8'hEF);
      wr(OFF_SRC0 + 8'h04, 8'h04);
      @(posedge ref_clk) cmp_out <= 2'h1;
      quiet(12);
      rdchk(OFF_GFLAG_L, 8'h10);
      wr(OFF_GEN_L, 8'hFF);
      take(VEC_GRP0 + 4'h4);
      rdchk(OFF_SRC0 + 8'h04, 8'h44);
      wr(OFF_SRC0 + 8'h04, 8'h00);
      // Two pending requests released together go out one at a time, slowly taken.
      slow = 1'b1;
      wr(OFF_CORE, 8'h02);
      wr(OFF_SRC0 + 8'h03, 8'h02);
      hit(19'h10);
      hit(19'h1);
      wr(OFF_CORE, 8'h07);
      take(VEC_CONV);
      quiet(6);
      wr(OFF_CORE, 8'h01);
      take(VEC_GRP0 + 4'h3);
      wr(OFF_SRC0 + 8'h03, 8'h00);
      slow = 1'b0;
      // Time base periods for each prescaler source.
      foreach (tbs[t])
      begin
         wr(OFF_PSC0 + 8'(tbs[t].u), {6'h00, tbs[t].sel});
         wr(OFF_SRC0 + 8'h06 + 8'(tbs[t].u), 8'h04);
         wr(OFF_CORE, 8'h01);
         wr(OFF_PTB0 + 8'(tbs[t].u), {5'h10, tbs[t].per});
         cnt = 0;
         while (irq_req_q !== 1'b1 && cnt < 3000)
         begin
            @(negedge ref_clk);
            cnt = cnt + 1;
         end
         chk1("period", 1'b1, cnt >= tbs[t].lo && cnt <= tbs[t].hi);
         take(VEC_GRP0 + 4'h6 + 4'(tbs[t].u));
         wr(OFF_PTB0 + 8'(tbs[t].u), 8'h00);
         wr(OFF_SRC0 + 8'h06 + 8'(tbs[t].u), 8'h00);
      end
      results();
   end
endmodule
